/* inc/irq_init_params.svh */
// Purpose: constants for the cascaded interrupt controller pair
// Assumes: 16-bit I/O addresses, byte-wide data
// Notes: offsets are the I/O port numbers themselves
`ifndef IRQ_INIT_PARAMS_SVH
`define IRQ_INIT_PARAMS_SVH

`define PORT_PRI_EVEN 16'h0020
`define PORT_PRI_ODD 16'h0021
`define PORT_SEC_EVEN 16'h00A0
`define PORT_SEC_ODD 16'h00A1

`define FIRST_MARK_BIT 4
`define FIRST_LEVEL_BIT 3
`define FIRST_SINGLE_BIT 1
`define OPTIONS_AEOI_BIT 1
`define OPTIONS_MULTI_BIT 4
`define CMD_SEL_BIT 3
`define EOI_CODE 3'h1
`define SPURIOUS_LEVEL 3'h7
`define RESET_BYTE 8'h00

`endif

/* inc/irq_init_pkg.sv */
// Purpose: types shared by the cascaded interrupt controller pair
// Assumes: nothing beyond the params header
// Notes: one ctl_t per controller, index 0 primary, 1 secondary
package irq_init_pkg;

	typedef enum logic [1:0] {
		INIT_IDLE,
		INIT_VECTOR,
		INIT_CASCADE,
		INIT_OPTIONS
	} init_state_t;

	typedef struct packed {
		init_state_t init_state;
		logic ready;
		logic level_mode;
		logic single;
		logic [4:0] vec_base;
		logic [7:0] cascade;
		logic aeoi;
		logic multi;
		logic [7:0] prev;
		logic [7:0] irr;
		logic [7:0] isr;
	} ctl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] data;
	} io_req_t;

	typedef struct packed {
		logic hit;
		logic [2:0] idx;
	} pick_t;

	typedef struct packed {
		logic hit;
		logic sec;
		logic odd;
	} port_t;

endpackage : irq_init_pkg

/* tb/cascaded_irq_controller_init_tb.sv */
// Purpose: self-checking bench for the cascaded controller pair
// Assumes: host model drives the port bus, bench drives request pins at the falling edge
// Notes: expected vectors come from a queue fed by the bench's own base and level
`timescale 1ns/1ns
`include "irq_init_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cascaded_irq_controller_init_tb;
	import irq_init_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [15:0] irq_in = '0;
	io_req_t io_req;
	logic inta;
	logic [7:0] rdata_q, vector_q, r;
	logic int_q, vector_valid_q, ok;
	logic [1:0] init_done_q;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 32'h04b608c8;
	int lvl, e;
	int p_base = 8'h08;
	int s_base = 8'h70;
	int exp_q[$];
	always #20 clk_sys = ~clk_sys;
	irq_init_pair u_irq_init_pair (.clk_sys(clk_sys), .reset(reset), .io_req(io_req),
		.inta(inta), .irq_in(irq_in), .rdata_q(rdata_q), .int_q(int_q),
		.vector_q(vector_q), .vector_valid_q(vector_valid_q), .init_done_q(init_done_q));
	host_model u_host_model (.clk_sys(clk_sys), .rdata_q(rdata_q), .vector_q(vector_q),
		.vector_valid_q(vector_valid_q), .io_req(io_req), .inta(inta));
	task automatic close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// ceiling well above the hundred-odd cycles the sequence needs
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic ack_chk();
		u_host_model.ack(r, ok);
		e = exp_q.pop_front();
		`CHK(ok, 1'b1)
		`CHK(r, e[7:0])
	endtask : ack_chk
	task automatic wait_int();
		for (int i = 0; i < 12 && int_q !== 1'b1; i++)
			@(negedge clk_sys);
		`CHK(int_q, 1'b1)
	endtask : wait_int
	initial begin
		repeat (10) @(negedge clk_sys);
		reset = 1'b0;
		u_host_model.init(`PORT_PRI_EVEN, 8'h10, p_base[7:0], 8'h04, 8'h02);
		`CHK(init_done_q, 2'b01)
		// secondary: multiple mode without automatic end
		u_host_model.init(`PORT_SEC_EVEN, 8'h10, s_base[7:0], 8'h02, 8'h10);
		`CHK(init_done_q, 2'b11)
		u_host_model.rd(`PORT_PRI_ODD, r);
		`CHK(r, 8'h00)
		$display("init test done");
		exp_q.push_back((p_base & 'hF8) | 7);
		ack_chk();
		repeat (3) begin
			lvl = {$random(seed)} % 7;
			if (lvl >= 2)
				lvl++;
			irq_in[lvl] = 1'b1;
			wait_int();
			exp_q.push_back((p_base & 'hF8) | lvl);
			ack_chk();
			irq_in = '0;
			u_host_model.rd(`PORT_PRI_EVEN, r);
			`CHK(r, 8'h00)
		end
		$display("primary test done");
		irq_in[10] = 1'b1;
		wait_int();
		exp_q.push_back((s_base & 'hF8) | 2);
		ack_chk();
		irq_in = '0;
		u_host_model.rd(`PORT_SEC_EVEN, r);
		`CHK(r, 8'h04)
		u_host_model.eoi(`PORT_SEC_EVEN);
		u_host_model.rd(`PORT_SEC_EVEN, r);
		`CHK(r, 8'h00)
		$display("cascade test done");
		u_host_model.wr(`PORT_PRI_EVEN, 8'h18);
		`CHK(init_done_q, 2'b10)
		`CHK(int_q, 1'b0)
		$display("restart test done");
		// level sensing without automatic end: request follows the pin, in-service stays
		u_host_model.init(`PORT_PRI_EVEN, 8'h18, p_base[7:0], 8'h04, 8'h00);
		`CHK(init_done_q, 2'b11)
		lvl = {$random(seed)} % 7;
		if (lvl >= 2)
			lvl++;
		irq_in[lvl] = 1'b1;
		wait_int();
		irq_in = '0;
		repeat (6) @(negedge clk_sys);
		`CHK(int_q, 1'b0)
		irq_in[lvl] = 1'b1;
		wait_int();
		exp_q.push_back((p_base & 'hF8) | lvl);
		ack_chk();
		u_host_model.rd(`PORT_PRI_EVEN, r);
		`CHK(r, 1 << lvl)
		u_host_model.eoi(`PORT_PRI_EVEN);
		u_host_model.rd(`PORT_PRI_EVEN, r);
		`CHK(r, 8'h00)
		wait_int();
		irq_in = '0;
		$display("level test done");
		close_out();
	end
endmodule : cascaded_irq_controller_init_tb

/* tb/host_model.sv */
// Purpose: host processor model issuing port writes, reads and acknowledges
// Assumes: strobes change at the falling edge and stay up for one cycle
// Notes: released address and data show inverted values so stale bytes never look valid
`timescale 1ns/1ns
module host_model (
	input wire logic clk_sys,
	input wire logic [7:0] rdata_q,
	input wire logic [7:0] vector_q,
	input wire logic vector_valid_q,
	output irq_init_pkg::io_req_t io_req,
	output logic inta
);
	import irq_init_pkg::*;
	initial begin
		io_req = '0;
		inta = 1'b0;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		io_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clk_sys);
		io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
	endtask : wr
	// whole series from the first word, single bit kept clear so the cascade word follows
	task automatic init(input logic [15:0] ev, input logic [7:0] w1, w2, w3, w4);
		wr(ev, w1 & 8'hFD);
		wr(ev + 16'h0001, w2);
		wr(ev + 16'h0001, w3);
		wr(ev + 16'h0001, w4);
	endtask : init
	// nonspecific end-of-interrupt leaving a routine without automatic end
	task automatic eoi(input logic [15:0] ev);
		wr(ev, 8'h20);
	endtask : eoi
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		io_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clk_sys);
		io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hFF};
		@(negedge clk_sys);
		d = rdata_q;
	endtask : rd
	task automatic ack(output logic [7:0] v, output logic ok);
		ok = 1'b0;
		v = 8'h00;
		repeat (2) begin
			@(negedge clk_sys);
			inta = 1'b1;
			@(negedge clk_sys);
			inta = 1'b0;
		end
		// vector pulse stands only one cycle, already up when the second strobe drops
		for (int i = 0; i < 4 && !ok; i++) begin
			ok = (vector_valid_q === 1'b1);
			v = vector_q;
			if (!ok)
				@(negedge clk_sys);
		end
	endtask : ack
endmodule : host_model

/* verilog/irq_init_pair.sv */
// Purpose: cascaded pair of interrupt controllers with their initialization sequence
// Assumes: io_req and inta come from bus logic on clk_sys; irq_in comes from pins
// Notes: operational commands limited to nonspecific end-of-interrupt
// Function
// - init words go in order from the first; odd-port writes decoded by position
// - primary serves requests 0-7, secondary 8-15, each on its own port pair
// - even-port write with bit 4 set is first word; bit 3 picks level sensing
// - second word gives vector bits 7:3; controller fills bits 2:0 with the level
// - bit 1 of the fourth word turns automatic end-of-interrupt on
// - automatic end-of-interrupt clears in-service level at end of second acknowledge
// - secondary fourth word bit 4 lets nested secondary requests through the primary
`timescale 1ns/1ns
`include "irq_init_params.svh"
module irq_init_pair (
	input wire logic clk_sys,
	input wire logic reset,
	input wire irq_init_pkg::io_req_t io_req,
	input wire logic inta,
	input wire logic [15:0] irq_in,
	output logic [7:0] rdata_q,
	output logic int_q,
	output logic [7:0] vector_q,
	output logic vector_valid_q,
	output logic [1:0] init_done_q
);
	import irq_init_pkg::*;

	function automatic pick_t highest(input logic [7:0] v);
		pick_t p;
		p = '0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				p.hit = 1'b1;
				p.idx = 3'(i);
			end
		end
		return p;
	endfunction : highest

	function automatic logic [7:0] onehot(input logic [2:0] i);
		return 8'(8'h01 << i);
	endfunction : onehot

	function automatic port_t decode(input logic [15:0] a);
		port_t p;
		p.hit = (a == `PORT_PRI_EVEN) || (a == `PORT_PRI_ODD) ||
			(a == `PORT_SEC_EVEN) || (a == `PORT_SEC_ODD);
		p.sec = (a == `PORT_SEC_EVEN) || (a == `PORT_SEC_ODD);
		p.odd = (a == `PORT_PRI_ODD) || (a == `PORT_SEC_ODD);
		return p;
	endfunction : decode

	logic [15:0] irq_meta_q;
	logic [15:0] irq_sync_q;
	ctl_t ctl_q [2];
	ctl_t ctl_d [2];
	logic phase_q, phase_d;
	logic from_sec_q, from_sec_d;
	logic [2:0] lvl_q, lvl_d;
	logic [7:0] rdata_d;
	logic int_d;
	logic [7:0] vector_d;
	logic vector_valid_d;

	port_t wport, rport;
	pick_t pk_s, ip_s, pk_p, ip_p, top;
	logic req_s, req_p, casc_hit;
	logic [7:0] casc, pend_p, blk_p;

	// pins cross into clk_sys through two flops
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_meta_q <= 16'h0000;
			irq_sync_q <= 16'h0000;
		end else begin
			irq_meta_q <= irq_in;
			irq_sync_q <= irq_meta_q;
		end
	end

	always_comb begin
		// secondary resolves first; its request feeds the primary cascade input
		pk_s = highest(ctl_q[1].irr);
		ip_s = highest(ctl_q[1].isr);
		req_s = ctl_q[1].ready && pk_s.hit && (!ip_s.hit || pk_s.idx < ip_s.idx);
		casc = ctl_q[0].single ? 8'h00 : ctl_q[0].cascade;
		pend_p = (ctl_q[0].irr & ~casc) | (casc & {8{req_s}});
		// in multiple mode the served cascade line does not block its own input
		blk_p = ctl_q[0].isr & ~(casc & {8{ctl_q[1].multi}});
		pk_p = highest(pend_p);
		ip_p = highest(blk_p);
		req_p = ctl_q[0].ready && pk_p.hit && (!ip_p.hit || pk_p.idx < ip_p.idx);
		casc_hit = casc[pk_p.idx] && (ctl_q[1].cascade[2:0] == pk_p.idx);

		ctl_d = ctl_q;
		phase_d = phase_q;
		from_sec_d = from_sec_q;
		lvl_d = lvl_q;
		vector_d = vector_q;
		vector_valid_d = 1'b0;
		int_d = req_p;
		rdata_d = rdata_q;
		wport = decode(io_req.addr);
		rport = wport;
		top = '0;

		if (io_req.wr && wport.hit) begin
			if (!wport.odd) begin
				if (io_req.data[`FIRST_MARK_BIT]) begin
					// restart: drop any half-done sequence and pending state
					ctl_d[wport.sec].init_state = INIT_VECTOR;
					ctl_d[wport.sec].ready = 1'b0;
					ctl_d[wport.sec].level_mode = io_req.data[`FIRST_LEVEL_BIT];
					ctl_d[wport.sec].single = io_req.data[`FIRST_SINGLE_BIT];
					ctl_d[wport.sec].irr = 8'h00;
					ctl_d[wport.sec].isr = 8'h00;
				end else if (!io_req.data[`CMD_SEL_BIT] && io_req.data[7:5] == `EOI_CODE) begin
					top = highest(ctl_q[wport.sec].isr);
					if (top.hit)
						ctl_d[wport.sec].isr = ctl_q[wport.sec].isr & ~onehot(top.idx);
				end
			end else begin
				unique case (ctl_q[wport.sec].init_state)
					INIT_VECTOR: begin
						ctl_d[wport.sec].vec_base = io_req.data[7:3];
						ctl_d[wport.sec].init_state = ctl_q[wport.sec].single ?
							INIT_OPTIONS : INIT_CASCADE;
					end
					INIT_CASCADE: begin
						ctl_d[wport.sec].cascade = io_req.data;
						ctl_d[wport.sec].init_state = INIT_OPTIONS;
					end
					INIT_OPTIONS: begin
						ctl_d[wport.sec].aeoi = io_req.data[`OPTIONS_AEOI_BIT];
						ctl_d[wport.sec].multi = io_req.data[`OPTIONS_MULTI_BIT];
						ctl_d[wport.sec].ready = 1'b1;
						ctl_d[wport.sec].init_state = INIT_IDLE;
					end
					INIT_IDLE: begin
						// mask register writes are not kept by this block
					end
				endcase
			end
		end

		if (inta) begin
			if (!phase_q) begin
				phase_d = 1'b1;
				if (req_p && casc_hit) begin
					ctl_d[0].isr = ctl_d[0].isr | onehot(pk_p.idx);
					ctl_d[1].isr = ctl_d[1].isr | onehot(pk_s.idx);
					ctl_d[1].irr = ctl_d[1].irr & ~onehot(pk_s.idx);
					from_sec_d = 1'b1;
					lvl_d = pk_s.idx;
				end else if (req_p) begin
					ctl_d[0].isr = ctl_d[0].isr | onehot(pk_p.idx);
					ctl_d[0].irr = ctl_d[0].irr & ~onehot(pk_p.idx);
					from_sec_d = 1'b0;
					lvl_d = pk_p.idx;
				end else begin
					// request vanished before acknowledge: answer level 7, the lowest priority
					from_sec_d = 1'b0;
					lvl_d = `SPURIOUS_LEVEL;
				end
			end else begin
				phase_d = 1'b0;
				vector_d = {ctl_q[from_sec_q].vec_base, lvl_q};
				vector_valid_d = 1'b1;
				// automatic end-of-interrupt at the close of the second acknowledge
				if (ctl_q[0].aeoi) begin
					top = highest(ctl_d[0].isr);
					if (top.hit)
						ctl_d[0].isr = ctl_d[0].isr & ~onehot(top.idx);
				end
				if (from_sec_q && ctl_q[1].aeoi) begin
					top = highest(ctl_d[1].isr);
					if (top.hit)
						ctl_d[1].isr = ctl_d[1].isr & ~onehot(top.idx);
				end
			end
		end

		// request sampling last so a new edge beats an acknowledge clear
		for (int c = 0; c < 2; c++) begin
			if (ctl_q[c].ready) begin
				if (ctl_q[c].level_mode)
					ctl_d[c].irr = irq_sync_q[c*8 +: 8];
				else
					ctl_d[c].irr = ctl_d[c].irr | (irq_sync_q[c*8 +: 8] & ~ctl_q[c].prev);
			end
			ctl_d[c].prev = irq_sync_q[c*8 +: 8];
		end

		// init words never read back; even port shows in-service state
		if (io_req.rd && rport.hit)
			rdata_d = rport.odd ? `RESET_BYTE : ctl_q[rport.sec].isr;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int c = 0; c < 2; c++)
				ctl_q[c] <= '0;
			phase_q <= 1'b0;
			from_sec_q <= 1'b0;
			lvl_q <= 3'h0;
			rdata_q <= 8'h00;
			int_q <= 1'b0;
			vector_q <= 8'h00;
			vector_valid_q <= 1'b0;
			init_done_q <= 2'h0;
		end else begin
			for (int c = 0; c < 2; c++)
				ctl_q[c] <= ctl_d[c];
			phase_q <= phase_d;
			from_sec_q <= from_sec_d;
			lvl_q <= lvl_d;
			rdata_q <= rdata_d;
			int_q <= int_d;
			vector_q <= vector_d;
			vector_valid_q <= vector_valid_d;
			init_done_q <= {ctl_d[1].ready, ctl_d[0].ready};
		end
	end

	property p_first_restart;
		@(posedge clk_sys) disable iff (reset)
		(io_req.wr && io_req.addr == `PORT_PRI_EVEN && io_req.data[`FIRST_MARK_BIT] && !inta)
			|=> (ctl_q[0].init_state == INIT_VECTOR && !init_done_q[0] && ctl_q[0].isr == 8'h00);
	endproperty
	a_first_restart: assert property (p_first_restart) else $error("first word did not restart");

	property p_level_flag;
		@(posedge clk_sys) disable iff (reset)
		(io_req.wr && io_req.addr == `PORT_SEC_EVEN && io_req.data[`FIRST_MARK_BIT])
			|=> ctl_q[1].level_mode == $past(io_req.data[`FIRST_LEVEL_BIT]);
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("trigger mode not taken");

	property p_order;
		@(posedge clk_sys) disable iff (reset)
		(io_req.wr && io_req.addr == `PORT_PRI_ODD && ctl_q[0].init_state == INIT_VECTOR
			&& !ctl_q[0].single) |=> (ctl_q[0].init_state == INIT_CASCADE
			&& ctl_q[0].vec_base == $past(io_req.data[7:3]));
	endproperty
	a_order: assert property (p_order) else $error("vector word misplaced");

	property p_vector;
		@(posedge clk_sys) disable iff (reset)
		(inta && phase_q) |=> (vector_valid_q && vector_q[2:0] == $past(lvl_q)) ##1 !vector_valid_q;
	endproperty
	a_vector: assert property (p_vector) else $error("vector low bits wrong");

	property p_aeoi;
		@(posedge clk_sys) disable iff (reset)
		(inta && phase_q && ctl_q[0].aeoi && !from_sec_q && ctl_q[0].isr != 8'h00
			&& !io_req.wr) |=> $countones(ctl_q[0].isr) == $countones($past(ctl_q[0].isr)) - 1;
	endproperty
	a_aeoi: assert property (p_aeoi) else $error("auto end-of-interrupt missing");

	property p_no_aeoi;
		@(posedge clk_sys) disable iff (reset)
		(inta && phase_q && !ctl_q[0].aeoi && !io_req.wr) |=> ctl_q[0].isr == $past(ctl_q[0].isr);
	endproperty
	a_no_aeoi: assert property (p_no_aeoi) else $error("in-service cleared without aeoi");

	property p_multi;
		@(posedge clk_sys) disable iff (reset)
		(ctl_q[0].ready && ctl_q[1].multi && req_s && casc != 8'h00
			&& (ctl_q[0].isr & ~casc) == 8'h00) |=> int_q;
	endproperty
	a_multi: assert property (p_multi) else $error("secondary nesting blocked");

	property p_cascade;
		@(posedge clk_sys) disable iff (reset)
		(inta && !phase_q && req_p && casc_hit) |=> (from_sec_q && ctl_q[1].isr != 8'h00);
	endproperty
	a_cascade: assert property (p_cascade) else $error("secondary not selected");

	property p_wo_read;
		@(posedge clk_sys) disable iff (reset)
		(io_req.rd && (io_req.addr == `PORT_PRI_ODD || io_req.addr == `PORT_SEC_ODD))
			|=> rdata_q == `RESET_BYTE;
	endproperty
	a_wo_read: assert property (p_wo_read) else $error("init word read back");

endmodule : irq_init_pair
